// file: pkg/scmc_defines.svh
`ifndef SCMC_DEFINES_SVH
`define SCMC_DEFINES_SVH

// ***************************************************************
// register byte addresses
// ***************************************************************
`define SCMC_ADDR_CSEL 8'h00
`define SCMC_ADDR_HIRCC 8'h04
`define SCMC_ADDR_LXTC 8'h08
`define SCMC_ADDR_MODE 8'h0C

// ***************************************************************
// field positions
// ***************************************************************
`define SCMC_CSEL_SEL_MSB 7
`define SCMC_CSEL_SEL_LSB 5
`define SCMC_CSEL_SRC 2
`define SCMC_CSEL_FHID 1
`define SCMC_CSEL_FSID 0
`define SCMC_HIRCC_FREQ_MSB 3
`define SCMC_HIRCC_FREQ_LSB 2
`define SCMC_HIRCC_FLAG 1
`define SCMC_HIRCC_EN 0
`define SCMC_LXTC_FLAG 1
`define SCMC_LXTC_EN 0
`define SCMC_MODE_RUN 7
`define SCMC_MODE_ESEL_MSB 6
`define SCMC_MODE_ESEL_LSB 4
`define SCMC_MODE_MODE_MSB 2
`define SCMC_MODE_MODE_LSB 0

// ***************************************************************
// reset values and codes
// ***************************************************************
`define SCMC_SEL_RST 3'h0
`define SCMC_SEL_SLOW 3'h7
`define SCMC_HIRCC_EN_RST 1'h1
`define SCMC_LXTC_EN_RST 1'h0

// ***************************************************************
// timing
// ***************************************************************
`define SCMC_CLK_MHZ 125
`define SCMC_XTAL_START_NS 1000000
`define SCMC_FRC_START_NS 16000
`define SCMC_NS_TO_CYC(ns) (((ns) * `SCMC_CLK_MHZ + 999) / 1000)

`endif

// file: pkg/scmc_pkg.sv
package scmc_pkg;

    // operating modes, two running and four halted
    typedef enum logic [2:0] {
        SCMC_MODE_FAST = 3'b000,
        SCMC_MODE_SLOW = 3'b001,
        SCMC_MODE_SLEEP = 3'b010,
        SCMC_MODE_IDLE_SLOW_ONLY = 3'b011,
        SCMC_MODE_IDLE_BOTH_CLOCKS = 3'b100,
        SCMC_MODE_IDLE_FAST_ONLY = 3'b101
    } scmc_mode_e;

    typedef logic [2:0] scmc_sel_t;

endpackage : scmc_pkg

// file: hw/scmc_sync.sv
`timescale 1ns/1ps
// ***************************************************************
// three-stage synchroniser with agreement filter and rise pulse
// ***************************************************************
module scmc_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic async_in,
    output logic rise
);
    logic ff1_reg;
    logic ff2_reg;
    logic ff3_reg;
    logic level_reg;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ff1_reg <= 1'b0;
            ff2_reg <= 1'b0;
            ff3_reg <= 1'b0;
        end else begin
            ff1_reg <= async_in;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
        end
    end

    // level moves only once stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level_reg <= 1'b0;
        end else if (ff2_reg == ff3_reg) begin
            level_reg <= ff3_reg;
        end
    end

    assign rise = (ff2_reg == ff3_reg) && ff3_reg && !level_reg;
endmodule : scmc_sync

// file: hw/scmc_osc_start.sv
`timescale 1ns/1ps
// ***************************************************************
// oscillator start-up timer and stable flag
// ***************************************************************
module scmc_osc_start #(
    parameter int unsigned CYCLES = 2000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic restart,
    output logic stable
);
    logic [31:0] cnt_reg;

    generate
        if (CYCLES < 2) begin : g_bad
            $error("scmc_osc_start: CYCLES must be at least 2");
        end
    endgenerate

    // flag drops on disable or restart, rises after the full delay
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 32'h0;
            stable <= 1'b0;
        end else if (!enable || restart) begin
            cnt_reg <= 32'h0;
            stable <= 1'b0;
        end else if (cnt_reg == CYCLES - 1) begin
            stable <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end
endmodule : scmc_osc_start

// file: hw/scmc_top.sv
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "scmc_defines.svh"

module scmc_top #(
    parameter int unsigned XTAL_START_CYCLES = `SCMC_NS_TO_CYC(`SCMC_XTAL_START_NS),
    parameter int unsigned FRC_START_CYCLES = `SCMC_NS_TO_CYC(`SCMC_FRC_START_NS)
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic HALT_REQ,
    input wire logic WAKE_REQ,
    input wire logic WDT_ENABLE,
    input wire logic CRYSTAL_CLK_IN,
    input wire logic SLOW_RC_CLK_IN,
    output logic PROC_CLK_EN,
    output logic PROC_RUN,
    output logic HS_CLK_EN,
    output logic LS_CLK_EN,
    output logic FAST_OSC_ON,
    output logic CRYSTAL_OSC_ON,
    output logic SLOW_RC_ON,
    output logic CRYSTAL_PINS_GPIO,
    output logic [2:0] MODE
);
    // ***************************************************************
    // declarations
    // ***************************************************************
    scmc_pkg::scmc_sel_t sel_reg;
    scmc_pkg::scmc_sel_t eff_sel_reg;
    scmc_pkg::scmc_mode_e mode_reg;
    scmc_pkg::scmc_mode_e mode_next;
    logic src_reg;
    logic eff_src_reg;
    logic fhid_reg;
    logic fsid_reg;
    logic hs_en_reg;
    logic lxt_en_reg;
    logic [1:0] hfreq_reg;
    logic [5:0] div_cnt_reg;
    logic apb_wr;
    logic apb_hit;
    logic freq_restart;
    logic halted;
    logic ls_run;
    logic fast_osc_next;
    logic crystal_next;
    logic rc_next;
    logic hs_stable;
    logic lxt_stable;
    logic xt_rise;
    logic rc_rise;
    logic ls_tick;
    logic fast_tick;
    logic target_ok;
    logic do_switch;
    logic [31:0] rdata_next;

    // ratio mask for the fast divider
    function automatic logic [5:0] div_mask(input scmc_pkg::scmc_sel_t sel);
        logic [5:0] m;
        m = 6'h00;
        case (sel)
            3'h0: m = 6'h00;
            3'h1: m = 6'h01;
            3'h2: m = 6'h03;
            3'h3: m = 6'h07;
            3'h4: m = 6'h0F;
            3'h5: m = 6'h1F;
            3'h6: m = 6'h3F;
            default: m = 6'h00;
        endcase
        return m;
    endfunction : div_mask

    // ***************************************************************
    // apb slave
    // ***************************************************************
    assign PREADY = 1'b1;
    assign apb_hit = (PADDR == `SCMC_ADDR_CSEL) || (PADDR == `SCMC_ADDR_HIRCC) ||
                     (PADDR == `SCMC_ADDR_LXTC) || (PADDR == `SCMC_ADDR_MODE);
    assign PSLVERR = PSEL && PENABLE && !apb_hit;
    assign apb_wr = PSEL && PENABLE && PWRITE && PSTRB[0] && apb_hit;
    assign freq_restart = apb_wr && (PADDR == `SCMC_ADDR_HIRCC) &&
                          (PWDATA[`SCMC_HIRCC_FREQ_MSB:`SCMC_HIRCC_FREQ_LSB] != hfreq_reg);

    // software-written control bits
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sel_reg <= `SCMC_SEL_RST;
            src_reg <= 1'b0;
            fhid_reg <= 1'b0;
            fsid_reg <= 1'b0;
            hs_en_reg <= `SCMC_HIRCC_EN_RST;
            hfreq_reg <= 2'h0;
            lxt_en_reg <= `SCMC_LXTC_EN_RST;
        end else if (apb_wr) begin
            case (PADDR)
                `SCMC_ADDR_CSEL: begin
                    sel_reg <= PWDATA[`SCMC_CSEL_SEL_MSB:`SCMC_CSEL_SEL_LSB];
                    src_reg <= PWDATA[`SCMC_CSEL_SRC];
                    fhid_reg <= PWDATA[`SCMC_CSEL_FHID];
                    fsid_reg <= PWDATA[`SCMC_CSEL_FSID];
                end
                `SCMC_ADDR_HIRCC: begin
                    hfreq_reg <= PWDATA[`SCMC_HIRCC_FREQ_MSB:`SCMC_HIRCC_FREQ_LSB];
                    hs_en_reg <= PWDATA[`SCMC_HIRCC_EN];
                end
                `SCMC_ADDR_LXTC: begin
                    lxt_en_reg <= PWDATA[`SCMC_LXTC_EN];
                end
                default: begin
                end
            endcase
        end
    end

    // read mux, captured in the setup cycle so data holds through access
    always_comb begin
        rdata_next = 32'h0;
        case (PADDR)
            `SCMC_ADDR_CSEL: begin
                rdata_next[`SCMC_CSEL_SEL_MSB:`SCMC_CSEL_SEL_LSB] = sel_reg;
                rdata_next[`SCMC_CSEL_SRC] = src_reg;
                rdata_next[`SCMC_CSEL_FHID] = fhid_reg;
                rdata_next[`SCMC_CSEL_FSID] = fsid_reg;
            end
            `SCMC_ADDR_HIRCC: begin
                rdata_next[`SCMC_HIRCC_FREQ_MSB:`SCMC_HIRCC_FREQ_LSB] = hfreq_reg;
                rdata_next[`SCMC_HIRCC_FLAG] = hs_stable;
                rdata_next[`SCMC_HIRCC_EN] = hs_en_reg;
            end
            `SCMC_ADDR_LXTC: begin
                rdata_next[`SCMC_LXTC_FLAG] = lxt_stable;
                rdata_next[`SCMC_LXTC_EN] = lxt_en_reg;
            end
            `SCMC_ADDR_MODE: begin
                rdata_next[`SCMC_MODE_RUN] = !halted;
                rdata_next[`SCMC_MODE_ESEL_MSB:`SCMC_MODE_ESEL_LSB] = eff_sel_reg;
                rdata_next[`SCMC_MODE_MODE_MSB:`SCMC_MODE_MODE_LSB] = mode_reg;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= 32'h0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rdata_next;
        end
    end

    // ***************************************************************
    // oscillator control
    // ***************************************************************
    assign halted = (mode_reg != scmc_pkg::SCMC_MODE_FAST) && (mode_reg != scmc_pkg::SCMC_MODE_SLOW);
    // low-speed clock alive while running or halted with its keep bit
    assign ls_run = !halted || fsid_reg;
    // fast oscillator also wakes for a pending move back to fast mode,
    // otherwise software would have to set the enable before switching
    assign fast_osc_next = halted ? fhid_reg :
                           ((eff_sel_reg != `SCMC_SEL_SLOW) || (sel_reg != `SCMC_SEL_SLOW) ||
                            hs_en_reg);
    assign crystal_next = lxt_en_reg && (ls_run || !src_reg);
    assign rc_next = (mode_reg != scmc_pkg::SCMC_MODE_SLEEP) || WDT_ENABLE;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            FAST_OSC_ON <= 1'b1;
            CRYSTAL_OSC_ON <= 1'b0;
            SLOW_RC_ON <= 1'b1;
            CRYSTAL_PINS_GPIO <= 1'b1;
        end else begin
            FAST_OSC_ON <= fast_osc_next;
            CRYSTAL_OSC_ON <= crystal_next;
            SLOW_RC_ON <= rc_next;
            CRYSTAL_PINS_GPIO <= !lxt_en_reg;
        end
    end

    scmc_osc_start #(.CYCLES(FRC_START_CYCLES)) u_hs_start (
        .clk(CLK),
        .resetn(RESETN),
        .enable(FAST_OSC_ON),
        .restart(freq_restart),
        .stable(hs_stable)
    );

    scmc_osc_start #(.CYCLES(XTAL_START_CYCLES)) u_xt_start (
        .clk(CLK),
        .resetn(RESETN),
        .enable(CRYSTAL_OSC_ON),
        .restart(1'b0),
        .stable(lxt_stable)
    );

    scmc_sync u_xt_sync (
        .clk(CLK),
        .resetn(RESETN),
        .async_in(CRYSTAL_CLK_IN),
        .rise(xt_rise)
    );

    scmc_sync u_rc_sync (
        .clk(CLK),
        .resetn(RESETN),
        .async_in(SLOW_RC_CLK_IN),
        .rise(rc_rise)
    );

    // ***************************************************************
    // clock selection and division
    // ***************************************************************
    // crystal ticks count only once it has settled
    assign ls_tick = eff_src_reg ? (xt_rise && lxt_stable) : (rc_rise && SLOW_RC_ON);
    assign target_ok = (sel_reg == `SCMC_SEL_SLOW) ? (src_reg ? lxt_stable : SLOW_RC_ON) : hs_stable;
    assign do_switch = !halted && target_ok &&
                       ((sel_reg != eff_sel_reg) || (src_reg != eff_src_reg));
    assign fast_tick = hs_stable && ((div_cnt_reg & div_mask(eff_sel_reg)) == 6'h00);

    // applied selection follows software once the target is stable
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            eff_sel_reg <= `SCMC_SEL_RST;
            eff_src_reg <= 1'b0;
        end else if (do_switch) begin
            eff_sel_reg <= sel_reg;
            eff_src_reg <= src_reg;
        end
    end

    // divider restarts on a switch so the first pulse is a whole one
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_cnt_reg <= 6'h00;
        end else if (do_switch) begin
            div_cnt_reg <= 6'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
        end
    end

    // registered clock enables to processor and peripherals
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            PROC_CLK_EN <= 1'b0;
            HS_CLK_EN <= 1'b0;
            LS_CLK_EN <= 1'b0;
        end else begin
            PROC_CLK_EN <= !halted &&
                           ((eff_sel_reg == `SCMC_SEL_SLOW) ? ls_tick : fast_tick);
            HS_CLK_EN <= FAST_OSC_ON && hs_stable;
            LS_CLK_EN <= ls_run && ls_tick;
        end
    end

    // ***************************************************************
    // operating mode machine
    // ***************************************************************
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            scmc_pkg::SCMC_MODE_FAST, scmc_pkg::SCMC_MODE_SLOW: begin
                if (HALT_REQ) begin
                    case ({fhid_reg, fsid_reg})
                        2'b00: mode_next = scmc_pkg::SCMC_MODE_SLEEP;
                        2'b01: mode_next = scmc_pkg::SCMC_MODE_IDLE_SLOW_ONLY;
                        2'b11: mode_next = scmc_pkg::SCMC_MODE_IDLE_BOTH_CLOCKS;
                        default: mode_next = scmc_pkg::SCMC_MODE_IDLE_FAST_ONLY;
                    endcase
                end else if (eff_sel_reg == `SCMC_SEL_SLOW) begin
                    mode_next = scmc_pkg::SCMC_MODE_SLOW;
                end else begin
                    mode_next = scmc_pkg::SCMC_MODE_FAST;
                end
            end
            scmc_pkg::SCMC_MODE_SLEEP, scmc_pkg::SCMC_MODE_IDLE_SLOW_ONLY,
            scmc_pkg::SCMC_MODE_IDLE_BOTH_CLOCKS, scmc_pkg::SCMC_MODE_IDLE_FAST_ONLY: begin
                if (WAKE_REQ) begin
                    mode_next = (eff_sel_reg == `SCMC_SEL_SLOW) ? scmc_pkg::SCMC_MODE_SLOW :
                                scmc_pkg::SCMC_MODE_FAST;
                end
            end
            default: mode_next = scmc_pkg::SCMC_MODE_FAST;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_reg <= scmc_pkg::SCMC_MODE_FAST;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign MODE = mode_reg;
    assign PROC_RUN = !halted;

    // ***************************************************************
    // assertions
    // ***************************************************************
    AST_RC_SOURCE: assert property (@(posedge CLK) disable iff (!RESETN)
        ls_run && !eff_src_reg && rc_rise && SLOW_RC_ON |=> LS_CLK_EN)
        else $error("slow RC tick not passed to low-speed clock");
    AST_XT_DELAY: assert property (@(posedge CLK) disable iff (!RESETN)
        $rose(CRYSTAL_OSC_ON) |-> !lxt_stable ##1 !lxt_stable)
        else $error("crystal flagged stable without start-up delay");
    AST_GPIO: assert property (@(posedge CLK) disable iff (!RESETN)
        CRYSTAL_OSC_ON |-> !CRYSTAL_PINS_GPIO)
        else $error("crystal pins in GPIO use while crystal runs");
    AST_DIV2: assert property (@(posedge CLK) disable iff (!RESETN)
        PROC_CLK_EN && mode_reg == scmc_pkg::SCMC_MODE_FAST && eff_sel_reg == 3'h1 && !do_switch &&
        !$past(do_switch)
        |=> !PROC_CLK_EN)
        else $error("divide-by-two pulses back to back");
    AST_SLOW_TICK: assert property (@(posedge CLK) disable iff (!RESETN)
        PROC_CLK_EN && $past(eff_sel_reg) == `SCMC_SEL_SLOW && !$past(halted) |-> $past(ls_tick))
        else $error("slow-mode processor pulse without low-speed tick");
    AST_SLOW_HS: assert property (@(posedge CLK) disable iff (!RESETN)
        mode_reg == scmc_pkg::SCMC_MODE_SLOW && sel_reg == `SCMC_SEL_SLOW &&
        eff_sel_reg == `SCMC_SEL_SLOW |=> FAST_OSC_ON == $past(hs_en_reg))
        else $error("slow-mode fast oscillator not following enable");
    AST_SLEEP: assert property (@(posedge CLK) disable iff (!RESETN)
        mode_reg == scmc_pkg::SCMC_MODE_SLEEP && $past(mode_reg) == scmc_pkg::SCMC_MODE_SLEEP
        |-> !PROC_CLK_EN && !LS_CLK_EN && !FAST_OSC_ON)
        else $error("clock running in sleep");
    AST_SLEEP_RC: assert property (@(posedge CLK) disable iff (!RESETN)
        mode_reg == scmc_pkg::SCMC_MODE_SLEEP && $past(mode_reg) == scmc_pkg::SCMC_MODE_SLEEP
        |-> SLOW_RC_ON == $past(WDT_ENABLE))
        else $error("slow RC not following watchdog in sleep");
    AST_IDLE_FAST: assert property (@(posedge CLK) disable iff (!RESETN)
        mode_reg == scmc_pkg::SCMC_MODE_IDLE_FAST_ONLY |=> FAST_OSC_ON && !LS_CLK_EN)
        else $error("fast-only idle clocks wrong");
    AST_SWITCH: assert property (@(posedge CLK) disable iff (!RESETN)
        eff_sel_reg != $past(eff_sel_reg) |-> $past(target_ok))
        else $error("clock switched to unstable source");
endmodule : scmc_top

// file: testbench/scmc_core_model.sv
`timescale 1ns/1ps
// ******************************
// processor core stand-in
// ******************************
module scmc_core_model (
    input wire logic clk,
    input wire logic proc_clk_en,
    input wire logic proc_run,
    output logic halt_req,
    output logic wake_req
);
    // idle outputs from time zero
    initial begin
        halt_req = 1'b0;
        wake_req = 1'b0;
    end

    // halt is an instruction, so it only issues on a processor clock cycle
    task automatic do_halt();
        @(negedge clk);
        while (!(proc_clk_en === 1'b1 && proc_run === 1'b1)) @(negedge clk);
        @(posedge clk);
        halt_req <= 1'b1;
        @(posedge clk);
        halt_req <= 1'b0;
    endtask : do_halt

    // wake event, one cycle long
    task automatic do_wake();
        @(posedge clk);
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
    endtask : do_wake
endmodule : scmc_core_model

// file: testbench/scmc_top_tb_top.sv
`timescale 1ns/1ps
`include "scmc_defines.svh"
module scmc_top_tb_top;
    localparam int XT_HALF = 5;
    localparam int RC_HALF = 7;
    logic clk, resetn, psel, penable, pwrite, halt_req, wake_req, wdt_en, xt_clk, rc_clk, err;
    logic pready, pslverr, proc_clk_en, proc_run, hs_clk_en, ls_clk_en, fast_on, xt_on, rc_on, gpio;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, w;
    logic [3:0] pstrb;
    logic [2:0] mode;
    int err_total, tests_run, cyc, xt_cnt, rc_cnt, np, nl, gp;
    int mode_tab[4] = '{2, 3, 5, 4};

    scmc_top #(.XTAL_START_CYCLES(8), .FRC_START_CYCLES(4)) DUT (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .HALT_REQ(halt_req), .WAKE_REQ(wake_req), .WDT_ENABLE(wdt_en), .CRYSTAL_CLK_IN(xt_clk),
        .SLOW_RC_CLK_IN(rc_clk), .PROC_CLK_EN(proc_clk_en), .PROC_RUN(proc_run), .HS_CLK_EN(hs_clk_en),
        .LS_CLK_EN(ls_clk_en), .FAST_OSC_ON(fast_on), .CRYSTAL_OSC_ON(xt_on), .SLOW_RC_ON(rc_on),
        .CRYSTAL_PINS_GPIO(gpio), .MODE(mode));

    scmc_core_model u_core (.clk(clk), .proc_clk_en(proc_clk_en), .proc_run(proc_run),
        .halt_req(halt_req), .wake_req(wake_req));

    // ******************************
    // clock, oscillators, timeout
    // ******************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // oscillators stand still while switched off, as real ones would
    always @(posedge clk) begin
        xt_cnt <= (xt_cnt == XT_HALF - 1) ? 0 : xt_cnt + 1;
        rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
        if (xt_on !== 1'b1) xt_clk <= 1'b0;
        else if (xt_cnt == XT_HALF - 1) xt_clk <= ~xt_clk;
        if (rc_on !== 1'b1) rc_clk <= 1'b0;
        else if (rc_cnt == RC_HALF - 1) rc_clk <= ~rc_clk;
    end

    // hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            finish_test();
        end
    end

    // ******************************
    // tasks
    // ******************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // counts clock-enable pulses; gp is the spacing of the last two processor pulses
    task automatic observe(input int n);
        int last;
        last = -1;
        np = 0;
        nl = 0;
        gp = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            if (proc_clk_en === 1'b1) begin
                if (last >= 0) gp = i - last;
                last = i;
                np++;
            end
            if (ls_clk_en === 1'b1) nl++;
        end
    endtask : observe

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    // ******************************
    // main sequence
    // ******************************
    initial begin
        {psel, penable, pwrite, resetn, wdt_en, xt_clk, rc_clk} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        {err_total, tests_run, cyc, xt_cnt, rc_cnt} = '0;
        void'($urandom(32'hF521));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (20) @(posedge clk);
        apb(1'b0, `SCMC_ADDR_CSEL, 0); chk(rd, 32'h0);
        apb(1'b0, `SCMC_ADDR_HIRCC, 0); chk(rd, 32'h3);
        apb(1'b0, `SCMC_ADDR_MODE, 0); chk(rd, 32'h80);
        chk({gpio, xt_on}, 2'b10);
        // unmapped place and a write with byte 0 masked off
        apb(1'b1, 8'h10, 32'hFF); chk(err, 1'b1);
        pstrb <= 4'hE;
        apb(1'b1, `SCMC_ADDR_CSEL, 32'hE3);
        pstrb <= 4'hF;
        apb(1'b0, `SCMC_ADDR_CSEL, 0); chk(rd, 32'h0);
        // divide ratios, random filler in the unused bits
        for (int s = 0; s < 7; s++) begin
            w = $urandom();
            w[7:5] = s[2:0];
            w[2:0] = 3'h0;
            apb(1'b1, `SCMC_ADDR_CSEL, w);
            apb(1'b0, `SCMC_ADDR_CSEL, 0); chk(rd, {24'h0, s[2:0], 5'h0});
            observe(200); chk(gp, 1 << s);
        end
        // crystal start-up: flag low first, pins taken from GPIO
        apb(1'b1, `SCMC_ADDR_LXTC, 1);
        apb(1'b0, `SCMC_ADDR_LXTC, 0); chk(rd, 32'h1);
        chk(gpio, 1'b0);
        repeat (200) @(posedge clk);
        apb(1'b0, `SCMC_ADDR_LXTC, 0); chk(rd, 32'h3);
        // slow mode on the crystal, then on the slow RC
        for (int f = 1; f >= 0; f--) begin
            apb(1'b1, `SCMC_ADDR_CSEL, {24'h0, 3'h7, 2'h0, f[0], 2'h0});
            observe(200); chk(gp, f ? 2 * XT_HALF : 2 * RC_HALF);
            apb(1'b0, `SCMC_ADDR_MODE, 0); chk(rd, 32'hF1);
        end
        // fast oscillator follows its enable while slow
        apb(1'b1, `SCMC_ADDR_HIRCC, 0);
        repeat (4) @(posedge clk);
        chk({fast_on, hs_clk_en}, 2'b00);
        apb(1'b1, `SCMC_ADDR_HIRCC, 1);
        repeat (20) @(posedge clk);
        chk({fast_on, hs_clk_en}, 2'b11);
        // a new frequency code drops the stable flag again
        apb(1'b1, `SCMC_ADDR_HIRCC, 32'h5);
        apb(1'b0, `SCMC_ADDR_HIRCC, 0); chk(rd, 32'h5);
        repeat (20) @(posedge clk);
        apb(1'b0, `SCMC_ADDR_HIRCC, 0); chk(rd, 32'h7);
        apb(1'b1, `SCMC_ADDR_HIRCC, 0);
        repeat (4) @(posedge clk);
        // back to fast while the oscillator is cold: the switch must wait
        apb(1'b1, `SCMC_ADDR_CSEL, 0);
        apb(1'b0, `SCMC_ADDR_MODE, 0); chk(rd, 32'hF1);
        repeat (20) @(posedge clk);
        apb(1'b0, `SCMC_ADDR_MODE, 0); chk(rd, 32'h80);
        // every keep combination, then sleep with the watchdog on
        for (int k = 0; k < 5; k++) begin
            wdt_en <= (k == 4);
            apb(1'b1, `SCMC_ADDR_CSEL, {30'h0, k[1:0]});
            u_core.do_halt();
            repeat (4) @(posedge clk);
            chk(mode, mode_tab[k[1:0]]);
            observe(60);
            chk({proc_run, np != 0, hs_clk_en, nl != 0}, {2'b00, k[1:0]});
            chk(rc_on, k != 0);
            u_core.do_wake();
            repeat (30) @(posedge clk);
            chk({proc_run, mode}, 4'h8);
        end
        finish_test();
    end
endmodule : scmc_top_tb_top
